/* rtl/flash_cmd_host.sv */
// host controller issuing command sequences to a parallel flash
`timescale 1ns/100ps
module flash_cmd_host
  import flash_host_pkg::*;
#(
  parameter int BLOCK_ADDR_BITS = 16,
  parameter int BUFFER_WORDS    = 16
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  output logic [23:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic             reset_powerdown_n,
  input  wire logic        status_pin
);
  flash_cycle_if cyc();

  flash_pin_cycle u_pins (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .cyc           (cyc),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n)
  );

  function automatic logic is_error(input logic [7:0] sr);
    is_error = sr[SR_ERASE_ERR] | sr[SR_PROG_ERR] | sr[SR_SUPPLY_ERR] | sr[SR_LOCK_ERR];
  endfunction : is_error

  function automatic logic same_block(input logic [23:0] a, input logic [23:0] b);
    same_block = (a[23:BLOCK_ADDR_BITS] == b[23:BLOCK_ADDR_BITS]);
  endfunction : same_block

  host_state_type state, next_state;
  logic [2:0]  op, next_op;
  logic [23:0] addr, next_addr;
  logic [15:0] data, next_data;
  logic [7:0]  count, next_count;
  logic [7:0]  idx, next_idx;
  logic [7:0]  status, next_status;
  logic [15:0] rdata, next_rdata;
  logic [1:0]  pin_cfg, next_pin_cfg;
  logic        busy, next_busy;
  logic        done, next_done;
  logic        refused, next_refused;
  logic        suspended, next_suspended;
  logic        pulse_seen, next_pulse_seen;
  logic        start, next_start;
  cycle_type   kind, next_kind;
  logic [23:0] caddr, next_caddr;
  logic [15:0] cdata, next_cdata;
  logic [31:0] next_reg_rdata;

  assign cyc.start = start;
  assign cyc.kind = kind;
  assign cyc.addr = caddr;
  assign cyc.wdata = cdata;

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_data = data;
    next_count = count;
    next_idx = idx;
    next_status = status;
    next_rdata = rdata;
    next_pin_cfg = pin_cfg;
    next_busy = busy;
    next_done = done;
    next_refused = refused;
    next_suspended = suspended;
    next_pulse_seen = pulse_seen | (~status_pin & (pin_cfg != 2'h0));
    next_start = 1'b0;
    next_kind = kind;
    next_caddr = caddr;
    next_cdata = cdata;
    next_reg_rdata = 32'h0;
    if (reg_read) begin
      case (reg_addr)
        REG_CONTROL: next_reg_rdata = {24'h0, pulse_seen, suspended, refused, done, busy, op};
        REG_ADDR:    next_reg_rdata = {8'h0, addr};
        REG_DATA:    next_reg_rdata = {16'h0, data};
        REG_COUNT:   next_reg_rdata = {24'h0, count};
        REG_STATUS:  next_reg_rdata = {24'h0, status};
        REG_RDATA:   next_reg_rdata = {16'h0, rdata};
        REG_PINCFG:  next_reg_rdata = {30'h0, pin_cfg};
        default:     next_reg_rdata = 32'h0;
      endcase
    end
    if (reg_write && !busy) begin
      case (reg_addr)
        REG_ADDR:   next_addr = reg_wdata[23:0];
        REG_DATA:   next_data = reg_wdata[15:0];
        REG_COUNT:  next_count = reg_wdata[7:0];
        REG_PINCFG: next_pin_cfg = reg_wdata[1:0] & PIN_CFG_MASK;
        REG_CONTROL: begin
          next_op = reg_wdata[2:0];
          next_refused = 1'b0;
          next_done = 1'b0;
          next_pulse_seen = 1'b0;
          // configuration only when idle and not suspended
          if ((reg_wdata[2:0] == OP_PINCFG && suspended) ||
              (reg_wdata[2:0] == OP_BUFFER && is_error(status)) ||
              (reg_wdata[2:0] == OP_CHIP && suspended) ||
              (suspended && reg_wdata[2:0] == OP_BUFFER)) begin
            next_refused = 1'b1;
            next_done = 1'b1;
          end else if (reg_wdata[2:0] == OP_BUFFER &&
                       (count >= 8'(BUFFER_WORDS) ||
                        !same_block(addr, addr + 24'(count)))) begin
            next_refused = 1'b1;
            next_done = 1'b1;
          end else begin
            next_busy = 1'b1;
            next_idx = 8'h0;
            next_state = ST_CMD;
          end
        end
        default: ;
      endcase
    end
    case (state)
      ST_IDLE: ;
      ST_CMD: begin
        next_start = 1'b1;
        next_kind = CYC_WRITE;
        next_caddr = addr;
        case (op)
          OP_READ:    next_cdata = {8'h0, CMD_READ_ARRAY};
          OP_PROGRAM: next_cdata = {8'h0, CMD_PROGRAM};
          OP_BUFFER:  next_cdata = {8'h0, CMD_BUFFER_WRITE};
          OP_CHIP:    next_cdata = {8'h0, CMD_CHIP_ERASE};
          OP_SUSPEND: next_cdata = {8'h0, CMD_SUSPEND};
          OP_RESUME:  next_cdata = {8'h0, CMD_RESUME};
          OP_CLEAR:   next_cdata = {8'h0, CMD_CLEAR_STATUS};
          OP_PINCFG:  next_cdata = {8'h0, CMD_PIN_CONFIG};
          default:    next_cdata = {8'h0, CMD_READ_STATUS};
        endcase
        next_state = ST_ARG;
      end
      ST_ARG: if (cyc.done) begin
        case (op)
          OP_READ: begin
            next_start = 1'b1;
            next_kind = CYC_READ;
            next_state = ST_READ;
          end
          OP_PROGRAM: begin
            next_start = 1'b1;
            next_cdata = data;
            next_state = ST_POLL;
          end
          OP_BUFFER: begin
            // read extended status; retry until a buffer is free
            next_start = 1'b1;
            next_kind = CYC_READ;
            next_state = ST_CHECK;
          end
          OP_CHIP: begin
            next_start = 1'b1;
            next_cdata = {8'h0, CMD_CONFIRM};
            next_state = ST_POLL;
          end
          OP_PINCFG: begin
            next_start = 1'b1;
            next_cdata = {14'h0, pin_cfg};
            next_state = ST_POLL;
          end
          OP_SUSPEND: begin
            next_suspended = 1'b1;
            next_state = ST_POLL;
            next_start = 1'b1;
            next_kind = CYC_READ;
          end
          OP_RESUME: begin
            next_suspended = 1'b0;
            next_state = ST_DONE;
          end
          default: next_state = ST_DONE;
        endcase
      end
      ST_CHECK: if (cyc.done) begin
        if (cyc.rdata[XSR_AVAILABLE]) begin
          next_start = 1'b1;
          next_kind = CYC_WRITE;
          next_cdata = {8'h0, count};
          next_state = ST_DATA;
        end else begin
          next_state = ST_CMD;
        end
      end
      ST_DATA: if (cyc.done) begin
        next_start = 1'b1;
        if (idx <= count) begin
          next_caddr = addr + 24'(idx);
          next_cdata = data;
          next_idx = idx + 8'h1;
        end else begin
          next_cdata = {8'h0, CMD_CONFIRM};
          next_state = ST_POLL;
        end
      end
      ST_POLL: if (cyc.done) begin
        next_start = 1'b1;
        next_kind = CYC_READ;
        next_state = ST_CONFIRM;
      end
      ST_CONFIRM: if (cyc.done) begin
        // status reads repeat until the ready bit rises
        if (cyc.rdata[SR_READY]) begin
          next_status = cyc.rdata[7:0];
          next_state = ST_DONE;
        end else begin
          next_start = 1'b1;
        end
      end
      ST_READ: if (cyc.done) begin
        next_rdata = cyc.rdata;
        next_state = ST_DONE;
      end
      ST_DONE: begin
        if (op == OP_CLEAR) begin
          next_status = 8'h80;
        end
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      op <= 3'h0;
      addr <= 24'h0;
      data <= 16'h0;
      count <= 8'h0;
      idx <= 8'h0;
      status <= 8'h80;
      rdata <= 16'h0;
      pin_cfg <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      suspended <= 1'b0;
      pulse_seen <= 1'b0;
      start <= 1'b0;
      kind <= CYC_NONE;
      caddr <= 24'h0;
      cdata <= 16'h0;
      reg_rdata <= 32'h0;
      reset_powerdown_n <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      data <= next_data;
      count <= next_count;
      idx <= next_idx;
      status <= next_status;
      rdata <= next_rdata;
      pin_cfg <= next_pin_cfg;
      busy <= next_busy;
      done <= next_done;
      refused <= next_refused;
      suspended <= next_suspended;
      pulse_seen <= next_pulse_seen;
      start <= next_start;
      kind <= next_kind;
      caddr <= next_caddr;
      cdata <= next_cdata;
      reg_rdata <= next_reg_rdata;
      reset_powerdown_n <= 1'b1;
    end
  end
endmodule : flash_cmd_host

/* rtl/flash_host_pkg.sv */
// constants and types shared by the flash command host controller
package flash_host_pkg;
  // command bytes; unlisted codes are arbitrary defaults, override per part
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT  = 8'h10;
  localparam logic [7:0] CMD_PIN_CONFIG   = 8'hB8;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h30;
  localparam logic [7:0] CMD_BUFFER_WRITE = 8'hE8;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_RESUME       = 8'hD0;

  // status register fields
  localparam int SR_READY      = 7;
  localparam int SR_SUSPENDED  = 6;
  localparam int SR_ERASE_ERR  = 5;
  localparam int SR_PROG_ERR   = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam int SR_LOCK_ERR   = 1;
  localparam int XSR_AVAILABLE = 7;

  // host register map (word index = address)
  localparam logic [3:0] REG_CONTROL = 4'h0; // w: op start; r: busy/done
  localparam logic [3:0] REG_ADDR    = 4'h1;
  localparam logic [3:0] REG_DATA    = 4'h2;
  localparam logic [3:0] REG_COUNT   = 4'h3; // buffer words minus one
  localparam logic [3:0] REG_STATUS  = 4'h4; // last status byte read
  localparam logic [3:0] REG_RDATA   = 4'h5; // last array data read
  localparam logic [3:0] REG_PINCFG  = 4'h6;

  // operation codes written to REG_CONTROL[2:0]
  localparam logic [2:0] OP_READ     = 3'h0;
  localparam logic [2:0] OP_PROGRAM  = 3'h1;
  localparam logic [2:0] OP_BUFFER   = 3'h2;
  localparam logic [2:0] OP_CHIP     = 3'h3;
  localparam logic [2:0] OP_SUSPEND  = 3'h4;
  localparam logic [2:0] OP_RESUME   = 3'h5;
  localparam logic [2:0] OP_CLEAR    = 3'h6;
  localparam logic [2:0] OP_PINCFG   = 3'h7;

  // pin bus timing at 10 MHz
  localparam int CLK_NS          = 100;
  localparam int WRITE_PULSE_NS  = 100;
  localparam int READ_ACCESS_NS  = 200;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] PIN_CFG_MASK = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CMD     = 4'h1,
    ST_ARG     = 4'h3,
    ST_DATA    = 4'h2,
    ST_CONFIRM = 4'h6,
    ST_POLL    = 4'h7,
    ST_CHECK   = 4'h5,
    ST_DONE    = 4'h4,
    ST_READ    = 4'hC
  } host_state_type;

  typedef enum logic [1:0] {
    CYC_NONE  = 2'h0,
    CYC_WRITE = 2'h1,
    CYC_READ  = 2'h2
  } cycle_type;
endpackage : flash_host_pkg

/* rtl/flash_cycle_if.sv */
// handshake between sequencer and pin cycle engine
`timescale 1ns/100ps
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic      start;
  cycle_type kind;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic      done;
  logic [15:0] rdata;
  modport seq (output start, kind, addr, wdata, input done, rdata);
  modport pins (input start, kind, addr, wdata, output done, rdata);
endinterface : flash_cycle_if

/* rtl/flash_pin_cycle.sv */
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/100ps
module flash_pin_cycle
  import flash_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  flash_cycle_if.pins      cyc,
  output logic [23:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n
);
  logic [2:0]  cnt, next_cnt;
  logic [1:0]  phase, next_phase;
  cycle_type   kind, next_kind;
  logic [23:0] next_addr;
  logic [15:0] next_dq, next_rdata;
  logic        next_oe_n_dq, next_ce, next_we, next_oe, next_done;

  always_comb begin
    next_cnt = cnt;
    next_phase = phase;
    next_kind = kind;
    next_addr = flash_addr;
    next_dq = flash_dq_out;
    next_rdata = cyc.rdata;
    next_oe_n_dq = flash_dq_oe_n;
    next_ce = flash_ce_n;
    next_we = flash_we_n;
    next_oe = flash_oe_n;
    next_done = 1'b0;
    case (phase)
      2'd0: if (cyc.start) begin
        next_kind = cyc.kind;
        next_addr = cyc.addr;
        next_dq = cyc.wdata;
        next_ce = 1'b0;
        next_oe_n_dq = (cyc.kind != CYC_WRITE);
        next_we = (cyc.kind != CYC_WRITE);
        next_oe = (cyc.kind != CYC_READ);
        next_cnt = (cyc.kind == CYC_WRITE) ? 3'(WRITE_PULSE_CYC) : 3'(READ_ACCESS_CYC);
        next_phase = 2'd1;
      end
      2'd1: begin
        if (cnt > 3'd1) begin
          next_cnt = cnt - 3'd1;
        end else begin
          // address and data stay put past the rising strobe edge
          next_rdata = flash_dq_in;
          next_we = 1'b1;
          next_oe = 1'b1;
          next_ce = 1'b1;
          next_phase = 2'd2;
        end
      end
      2'd2: begin
        next_oe_n_dq = 1'b1;
        next_done = 1'b1;
        next_phase = 2'd0;
      end
      default: next_phase = 2'd0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 3'h0;
      phase <= 2'h0;
      kind <= CYC_NONE;
      flash_addr <= 24'h0;
      flash_dq_out <= 16'h0;
      cyc.rdata <= 16'h0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      cyc.done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
      kind <= next_kind;
      flash_addr <= next_addr;
      flash_dq_out <= next_dq;
      cyc.rdata <= next_rdata;
      flash_dq_oe_n <= next_oe_n_dq;
      flash_ce_n <= next_ce;
      flash_we_n <= next_we;
      flash_oe_n <= next_oe;
      cyc.done <= next_done;
    end
  end
endmodule : flash_pin_cycle

/* verif/flash_cmd_host_chk.sv */
// pin and register port checks for the flash command host
`timescale 1ns/100ps
module flash_cmd_host_chk
  import flash_host_pkg::*;
#(
  parameter int BLOCK_ADDR_BITS = 16,
  parameter int BUFFER_WORDS    = 16
)(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        flash_dq_oe_n,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic        reset_powerdown_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> ##[0:3] reset_powerdown_n ##1 reset_powerdown_n[*8]; endproperty
  a_rst: assert property (p_rst) else $error("device reset not released");
  property p_wr_len; $fell(flash_we_n) |=> flash_we_n; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe not one cycle");
  property p_wr_drive; !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write without select or data");
  // data is held one cycle past the rising strobe for hold time
  property p_dq_free; flash_we_n && $past(flash_we_n) |-> flash_dq_oe_n; endproperty
  a_dq_free: assert property (p_dq_free) else $error("data driven outside write");
  property p_rd_len; $fell(flash_oe_n) |-> !flash_ce_n ##1 !flash_oe_n ##1 flash_oe_n; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle length wrong");
  property p_no_clash; !flash_oe_n |-> flash_we_n && flash_dq_oe_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("read overlaps drive");
  property p_ce_use; !flash_ce_n |-> !flash_we_n || !flash_oe_n; endproperty
  a_ce_use: assert property (p_ce_use) else $error("select without strobe");
  property p_rdata; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : flash_cmd_host_chk
bind flash_cmd_host flash_cmd_host_chk #(.BLOCK_ADDR_BITS(BLOCK_ADDR_BITS), .BUFFER_WORDS(BUFFER_WORDS))
  flash_cmd_host_chk_i (.clk(clk), .sys_rst(sys_rst), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .reset_powerdown_n(reset_powerdown_n));

/* verif/flash_dev_model.sv */
// behavioural flash device answering the host's pin cycles
`timescale 1ns/100ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_CYC  = 12,
  parameter int NBLK      = 32,
  parameter int XSR_WAITS = 2
)(
  input  wire logic        clk,
  input  wire logic [23:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic        fail_next,
  output logic [15:0]      flash_dq_in,
  output logic             status_pin
);
  logic [7:0]  sr = 8'h0;
  logic [7:0]  last_setup;
  logic [15:0] d;
  logic [15:0] last_data;
  logic [15:0] drv = 16'h5A5A;
  logic [23:0] a;
  logic [23:0] last_addr;
  logic [1:0]  cfg = 2'h0;
  logic        we_q = 1'b1;
  logic        xsr_mode, xsr_av, erase_op;
  int          busy, phase, left, pulse, xsr_wait, n_erased, n_buf_words, n_xsr, n_pulse;
  assign flash_dq_in = drv;
  assign status_pin  = (cfg == 2'h0) ? (busy == 0) : (pulse == 0);
  always @(posedge clk or negedge reset_powerdown_n) begin
    if (!reset_powerdown_n) begin
      cfg = 2'h0;
      busy = 0;
      phase = 0;
      pulse = 0;
      xsr_wait = XSR_WAITS;
    end else begin
      if (!flash_ce_n && !flash_we_n) begin
        a = flash_addr;
        d = flash_dq_out;
      end
      // released bus toggles so a stale sample never matches
      drv <= (!flash_ce_n && !flash_oe_n) ? (xsr_mode ? {8'h0, xsr_av, 7'h0} : {8'h0, busy == 0, sr[6:0]}) : ~drv;
      if (pulse > 0) pulse--;
      if (busy == 1) begin
        if (fail_next && !erase_op) sr[SR_PROG_ERR] = 1'b1;
        if (erase_op ? cfg[0] : cfg[1]) pulse = 3;
        if (erase_op ? cfg[0] : cfg[1]) n_pulse++;
      end
      if (busy > 0) busy--;
      if (!we_q && flash_we_n) begin
        case (phase)
          1: begin
            last_addr = a;
            last_data = d;
            busy = BUSY_CYC;
            erase_op = 1'b0;
          end
          2: begin
            if (d[7:0] == CMD_CONFIRM) n_erased = NBLK;
            if (d[7:0] == CMD_CONFIRM) erase_op = 1'b1;
            if (d[7:0] == CMD_CONFIRM) busy = BUSY_CYC * NBLK;
            else sr = sr | 8'h30;
          end
          3: left = d + 1;
          4: begin
            n_buf_words++;
            left--;
          end
          5: begin
            xsr_mode = 1'b0;
            if (d[7:0] == CMD_CONFIRM) busy = BUSY_CYC;
            else sr = sr | 8'h30;
            erase_op = 1'b0;
          end
          6: begin
            if (d[7:2] != 6'h0) sr = sr | 8'h30;
            else cfg = d[1:0];
          end
          default: begin
            xsr_mode = 1'b0;
            case (d[7:0])
              CMD_PROGRAM, CMD_PROGRAM_ALT: last_setup = d[7:0];
              CMD_BUFFER_WRITE: begin
                xsr_mode = 1'b1;
                n_xsr++;
                xsr_av = (xsr_wait == 0) && (sr[5:4] == 2'h0);
                if (xsr_wait > 0) xsr_wait--;
              end
              CMD_CLEAR_STATUS: sr[5:1] = 5'h0;
              CMD_PIN_CONFIG: if (busy != 0) sr = sr | 8'h30;
              CMD_CHIP_ERASE, CMD_READ_STATUS, CMD_READ_ARRAY, CMD_SUSPEND, CMD_RESUME: ;
              default: sr = sr | 8'h30;
            endcase
          end
        endcase
        // sequence position is recomputed on every taken write; unlisted first bytes keep it at 0
        if (phase == 0) phase = (d[7:0] == CMD_PROGRAM || d[7:0] == CMD_PROGRAM_ALT) ? 1 :
          (d[7:0] == CMD_CHIP_ERASE) ? 2 : (d[7:0] == CMD_BUFFER_WRITE && xsr_av) ? 3 :
          (d[7:0] == CMD_PIN_CONFIG && busy == 0) ? 6 : 0;
        else if (phase == 3 || phase == 4) phase = (left == 0) ? 5 : 4;
        else phase = 0;
      end
      we_q = flash_we_n;
    end
  end
endmodule : flash_dev_model

/* verif/flash_cmd_host_test.sv */
// self-checking bench for the flash command host
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module flash_cmd_host_test;
  import flash_host_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_type;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        fail_next = 1'b0;
  logic        pend = 1'b0;
  logic [31:0] reg_rdata, last_rd, a, v;
  logic [23:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  logic        flash_dq_oe_n, flash_ce_n, flash_we_n, flash_oe_n, reset_powerdown_n, status_pin;
  int          err_total = 0;
  int          comparisons = 0;
  int          nb;
  int          blo[5] = '{0, 0, 16, 0, 254};
  int          bct[5] = '{0, 7, 15, 16, 3};
  note_type    notes[$];
  note_type    n;
  flash_cmd_host #(.BLOCK_ADDR_BITS(8), .BUFFER_WORDS(16)) flash_cmd_host_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .reset_powerdown_n(reset_powerdown_n), .status_pin(status_pin));
  flash_dev_model flash_dev_model_i (.clk(clk), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .reset_powerdown_n(reset_powerdown_n), .fail_next(fail_next), .flash_dq_in(flash_dq_in),
    .status_pin(status_pin));
  initial begin
    forever #50 clk = ~clk;
  end
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (pend) begin
      last_rd = reg_rdata;
      n = notes.pop_front();
      if (n.m != 32'h0) `CHK(reg_rdata & n.m, n.e)
    end
    pend = reg_read;
  end
  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= dt;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    @(posedge clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    #1;
  endtask : rd
  // polls the done flag; a stuck operation counts as a mismatch
  task automatic run_op(input logic [2:0] op);
    int k;
    k = 0;
    wr(REG_CONTROL, {29'h0, op});
    do begin
      rd(REG_CONTROL, 32'h0, 32'h0);
      k++;
    end while (!(last_rd[4] === 1'b1 && last_rd[3] === 1'b0) && k < 600);
    `CHK(k < 600, 1'b1)
  endtask : run_op
  initial begin
    #(100 * 80000);
    err_total++;
    give_verdict();
  end
  initial begin
    a = $urandom(27);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(reset_powerdown_n, 1'b1)
    a = $urandom & 32'h00FF_FFFE;
    v = $urandom & 32'h0000_FFFF;
    wr(REG_ADDR, a);
    wr(REG_DATA, v);
    run_op(OP_PROGRAM);
    rd(REG_CONTROL, 32'h11, 32'h3F);
    rd(REG_STATUS, 32'h80, 32'hBA);
    `CHK(flash_dev_model_i.last_addr, a[23:0])
    `CHK(flash_dev_model_i.last_data, v[15:0])
    `CHK(flash_dev_model_i.last_setup, CMD_PROGRAM)
    run_op(OP_CHIP);
    rd(REG_STATUS, 32'h80, 32'hBA);
    `CHK(flash_dev_model_i.n_erased, 32)
    for (int i = 0; i < 5; i++) begin
      nb = flash_dev_model_i.n_buf_words;
      wr(REG_ADDR, ($urandom & 32'h00FF_FF00) | blo[i]);
      wr(REG_DATA, $urandom & 32'h0000_FFFF);
      wr(REG_COUNT, bct[i]);
      run_op(OP_BUFFER);
      rd(REG_CONTROL, (i < 3) ? 32'h12 : 32'h32, 32'h3F);
      `CHK(flash_dev_model_i.n_buf_words - nb, (i < 3) ? bct[i] + 1 : 0)
      if (i == 0) `CHK(flash_dev_model_i.n_xsr, 3)
    end
    fail_next <= 1'b1;
    run_op(OP_PROGRAM);
    fail_next <= 1'b0;
    rd(REG_STATUS, 32'h90, 32'hBA);
    nb = flash_dev_model_i.n_buf_words;
    wr(REG_COUNT, 32'h0);
    run_op(OP_BUFFER);
    rd(REG_CONTROL, 32'h32, 32'h3F);
    `CHK(flash_dev_model_i.n_buf_words, nb)
    run_op(OP_PROGRAM);
    rd(REG_STATUS, 32'h90, 32'hBA);
    run_op(OP_CLEAR);
    run_op(OP_PROGRAM);
    rd(REG_STATUS, 32'h80, 32'hBA);
    for (int c = 3; c >= 0; c--) begin
      wr(REG_PINCFG, c);
      run_op(OP_PINCFG);
      `CHK(flash_dev_model_i.cfg, c[1:0])
      nb = flash_dev_model_i.n_pulse;
      run_op(OP_PROGRAM);
      run_op(OP_CHIP);
      `CHK(last_rd[7], c[0])
      `CHK(flash_dev_model_i.n_pulse - nb, c[1] + c[0])
    end
    wr(4'hF, $urandom);
    run_op(OP_SUSPEND);
    run_op(OP_RESUME);
    rd(REG_STATUS, 32'h80, 32'hFA);
    give_verdict();
  end
endmodule : flash_cmd_host_test
